/* File: rtl/fsirq_consts.svh */
// Offsets, field positions, event and control bits, reset values and system fault code of the status block
`ifndef FSIRQ_CONSTS_SVH
`define FSIRQ_CONSTS_SVH
`define FSIRQ_OFS_MODE_WORD   12'h000
`define FSIRQ_OFS_TIRQ_WORD   12'h004
`define FSIRQ_OFS_FAULT_CODE  12'h008
`define FSIRQ_OFS_SETPOINT    12'h00c
`define FSIRQ_OFS_EVENT       12'h010
`define FSIRQ_OFS_CONTROL     12'h014
`define FSIRQ_BIT_STARTUP_PROT 9
`define FSIRQ_BIT_RUN_ALWAYS  12
`define FSIRQ_BIT_HALTED      13
`define FSIRQ_BIT_LOCK        14
`define FSIRQ_BIT_FIRST_SCAN  15
`define FSIRQ_BIT_PENDING     0
`define FSIRQ_BIT_ENABLE      1
`define FSIRQ_BIT_EXECUTING   2
`define FSIRQ_EV_MAJOR_ERR    0
`define FSIRQ_EV_SCAN_END     1
`define FSIRQ_EV_ROUTINE_END  2
`define FSIRQ_EV_START_INSTR  3
`define FSIRQ_EV_ENABLE_INSTR 4
`define FSIRQ_EV_DISABLE_INSTR 5
`define FSIRQ_EV_FAULT_EXIT   6
`define FSIRQ_EV_PROG_CLEAR   7
`define FSIRQ_EV_MAIN_START   8
`define FSIRQ_EV_POWER_UP     9
`define FSIRQ_CTL_ONLINE      0
`define FSIRQ_CTL_REQ_RUN     1
`define FSIRQ_CTL_REQ_TEST    2
`define FSIRQ_CTL_REQ_PROG    3
`define FSIRQ_RST_MODE_WORD   16'h0000
`define FSIRQ_RST_SETPOINT    16'h0000
`define FSIRQ_RST_FAULT_CODE  16'h0000
`define FSIRQ_SYSTEM_CODE     16'h0001
`endif

/* File: rtl/fsirq_pkg.sv */
// Types shared by the status block
package fsirq_pkg;
  typedef enum logic [3:0] {
    FSIRQ_PROG  = 4'b0001,
    FSIRQ_RUN   = 4'b0010,
    FSIRQ_TEST  = 4'b0100,
    FSIRQ_FAULT = 4'b1000
  } fsirq_mode_e;
  typedef struct packed {
    logic        first_scan;
    logic        lock;
    logic        halted;
    logic        run_always;
    logic        startup_prot;
  } fsirq_mode_s;
  typedef struct packed {
    logic        executing;
    logic        enable;
    logic        pending;
  } fsirq_tirq_s;
endpackage

/* File: rtl/fsirq_status.sv */
// Fault status, first-scan and timed interrupt flags behind an APB slave
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fsirq_consts.svh"
module fsirq_status #(
  parameter int TICK_DIV = 50000
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        password_ok,
  input  wire logic        major_error_pin,
  output logic             outputs_enable,
  output logic             fault_indicator,
  output logic             fault_routine_active,
  output logic             timed_irq_run,
  output logic             program_access,
  output var fsirq_pkg::fsirq_mode_e mode
);
  logic                    me_s1;
  logic                    me_s2;
  fsirq_pkg::fsirq_mode_e  next_mode;
  fsirq_pkg::fsirq_mode_s  mw;
  fsirq_pkg::fsirq_mode_s  next_mw;
  fsirq_pkg::fsirq_tirq_s  tw;
  fsirq_pkg::fsirq_tirq_s  next_tw;
  logic [15:0]             fault_code;
  logic [15:0]             next_fault_code;
  logic [15:0]             setpoint;
  logic [15:0]             next_setpoint;
  logic [15:0]             tick_cnt;
  logic [15:0]             next_tick_cnt;
  logic [15:0]             ivl_cnt;
  logic [15:0]             next_ivl_cnt;
  logic                    in_froutine;
  logic                    next_in_froutine;
  logic                    online;
  logic                    next_online;
  logic                    wr;
  logic                    rd_hit;
  logic [31:0]             next_prdata;
  logic [15:0]             ev;
  logic                    expiry;
  logic                    run_or_test;

  // Pin is asynchronous to the scan clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      me_s1 <= 1'b0;
      me_s2 <= 1'b0;
    end else begin
      me_s1 <= major_error_pin;
      me_s2 <= me_s1;
    end
  end

  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd_hit  = (paddr == `FSIRQ_OFS_MODE_WORD)
                 | (paddr == `FSIRQ_OFS_TIRQ_WORD)
                 | (paddr == `FSIRQ_OFS_FAULT_CODE)
                 | (paddr == `FSIRQ_OFS_SETPOINT)
                 | (paddr == `FSIRQ_OFS_EVENT)
                 | (paddr == `FSIRQ_OFS_CONTROL);
  assign pslverr = psel & penable & ~rd_hit;
  assign ev      = (wr && paddr == `FSIRQ_OFS_EVENT) ? pwdata[15:0] : 16'h0000;
  assign run_or_test = (mode == fsirq_pkg::FSIRQ_RUN)
                     | (mode == fsirq_pkg::FSIRQ_TEST);

  // Tick prescaler and interval timer; counting ignores the enable flag
  always_comb begin
    next_tick_cnt = tick_cnt + 16'h0001;
    next_ivl_cnt  = ivl_cnt;
    expiry        = 1'b0;
    if (tick_cnt == 16'(TICK_DIV - 1)) begin
      next_tick_cnt = 16'h0000;
      if (setpoint != 16'h0000 && run_or_test) begin
        if (ivl_cnt >= setpoint - 16'h0001) begin
          next_ivl_cnt = 16'h0000;
          expiry       = 1'b1;
        end else begin
          next_ivl_cnt = ivl_cnt + 16'h0001;
        end
      end
    end
  end

  always_comb begin
    next_mode       = mode;
    next_mw         = mw;
    next_tw         = tw;
    next_fault_code = fault_code;
    next_setpoint   = setpoint;
    next_in_froutine = in_froutine;
    next_online     = online;
    // Software writes to the status words and fault code
    if (wr && paddr == `FSIRQ_OFS_MODE_WORD) begin
      next_mw.startup_prot = pwdata[`FSIRQ_BIT_STARTUP_PROT];
      next_mw.run_always   = pwdata[`FSIRQ_BIT_RUN_ALWAYS];
      next_mw.lock         = pwdata[`FSIRQ_BIT_LOCK];
      if (pwdata[`FSIRQ_BIT_HALTED] && !mw.halted) begin
        next_mw.halted = 1'b1;
        if (mode == fsirq_pkg::FSIRQ_RUN) begin
          next_in_froutine = 1'b1;
        end else begin
          next_mode = fsirq_pkg::FSIRQ_FAULT;
        end
      end else if (!pwdata[`FSIRQ_BIT_HALTED]) begin
        next_mw.halted = 1'b0;
      end
    end
    if (wr && paddr == `FSIRQ_OFS_TIRQ_WORD && !online) begin
      next_tw.enable = pwdata[`FSIRQ_BIT_ENABLE];
    end
    // Online edit ignored by the timed interrupt
    if (wr && paddr == `FSIRQ_OFS_FAULT_CODE) begin
      next_fault_code = pwdata[15:0];
    end
    if (wr && paddr == `FSIRQ_OFS_SETPOINT) begin
      next_setpoint = pwdata[15:0];
    end
    if (wr && paddr == `FSIRQ_OFS_CONTROL) begin
      next_online = pwdata[`FSIRQ_CTL_ONLINE];
      if (!mw.halted && pwdata[`FSIRQ_CTL_REQ_RUN]) begin
        next_mode = fsirq_pkg::FSIRQ_RUN;
        next_mw.first_scan = 1'b1;
      end else if (!mw.halted && pwdata[`FSIRQ_CTL_REQ_TEST]) begin
        next_mode = fsirq_pkg::FSIRQ_TEST;
        next_mw.first_scan = 1'b1;
      end else if (pwdata[`FSIRQ_CTL_REQ_PROG] && !mw.halted) begin
        next_mode = fsirq_pkg::FSIRQ_PROG;
      end
    end
    if (ev[`FSIRQ_EV_SCAN_END] && !in_froutine) begin
      next_mw.first_scan = 1'b0;
    end
    // Power-up: run-always clears halted, startup protection in run mode runs routine
    if (ev[`FSIRQ_EV_POWER_UP]) begin
      if (mw.run_always) begin
        next_mw.halted = 1'b0;
        next_mode = fsirq_pkg::FSIRQ_RUN;
        next_mw.first_scan = 1'b1;
      end else if (mw.startup_prot && mode == fsirq_pkg::FSIRQ_RUN) begin
        // First scan held through startup routine
        next_mw.first_scan = 1'b1;
        next_in_froutine = 1'b1;
        next_mw.halted = 1'b1;
      end else if (mode == fsirq_pkg::FSIRQ_RUN) begin
        next_mw.first_scan = 1'b1;
      end
    end
    if (ev[`FSIRQ_EV_FAULT_EXIT] && in_froutine) begin
      next_in_froutine = 1'b0;
      if (next_mw.halted) begin
        next_mode = fsirq_pkg::FSIRQ_FAULT;
      end
    end
    // Programmer clear goes to remote program
    if (ev[`FSIRQ_EV_PROG_CLEAR] && mw.halted) begin
      next_mw.halted = 1'b0;
      next_in_froutine = 1'b0;
      next_mode = fsirq_pkg::FSIRQ_PROG;
    end
    // Major error wins over any clear
    if (me_s2 || ev[`FSIRQ_EV_MAJOR_ERR]) begin
      next_mw.halted = 1'b1;
      next_fault_code = `FSIRQ_SYSTEM_CODE;
      if (mode == fsirq_pkg::FSIRQ_RUN) begin
        next_in_froutine = 1'b1;
      end else begin
        next_mode = fsirq_pkg::FSIRQ_FAULT;
      end
    end
    if (ev[`FSIRQ_EV_START_INSTR] || ev[`FSIRQ_EV_ENABLE_INSTR]) begin
      next_tw.enable = 1'b1;
    end
    if (ev[`FSIRQ_EV_DISABLE_INSTR]) begin
      next_tw.enable = 1'b0;
    end
    if (ev[`FSIRQ_EV_START_INSTR] || ev[`FSIRQ_EV_MAIN_START]) begin
      next_tw.pending = 1'b0;
    end
    // Executing cleared at routine end or main start
    if (ev[`FSIRQ_EV_ROUTINE_END] || ev[`FSIRQ_EV_MAIN_START]) begin
      next_tw.executing = 1'b0;
    end
    if (expiry) begin
      if (tw.enable) begin
        next_tw.executing = 1'b1;
        next_tw.pending   = 1'b0;
      end else begin
        next_tw.pending = 1'b1;
      end
    end
    if (tw.pending && tw.enable && !tw.executing && !expiry) begin
      next_tw.pending   = 1'b0;
      next_tw.executing = 1'b1;
    end
    // Leaving run or test clears both flags
    if (run_or_test && next_mode != fsirq_pkg::FSIRQ_RUN
        && next_mode != fsirq_pkg::FSIRQ_TEST) begin
      next_tw.pending   = 1'b0;
      next_tw.executing = 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      unique case (paddr)
        `FSIRQ_OFS_MODE_WORD: begin
          next_prdata[`FSIRQ_BIT_STARTUP_PROT] = mw.startup_prot;
          next_prdata[`FSIRQ_BIT_RUN_ALWAYS]   = mw.run_always;
          next_prdata[`FSIRQ_BIT_HALTED]       = mw.halted;
          next_prdata[`FSIRQ_BIT_LOCK]         = mw.lock;
          next_prdata[`FSIRQ_BIT_FIRST_SCAN]   = mw.first_scan;
        end
        `FSIRQ_OFS_TIRQ_WORD: begin
          next_prdata[`FSIRQ_BIT_PENDING]   = tw.pending;
          next_prdata[`FSIRQ_BIT_ENABLE]    = tw.enable;
          next_prdata[`FSIRQ_BIT_EXECUTING] = tw.executing;
        end
        `FSIRQ_OFS_FAULT_CODE: next_prdata[15:0] = fault_code;
        `FSIRQ_OFS_SETPOINT:   next_prdata[15:0] = setpoint;
        `FSIRQ_OFS_CONTROL:    next_prdata[3:0]  = {mode == fsirq_pkg::FSIRQ_PROG,
                                 mode == fsirq_pkg::FSIRQ_TEST,
                                 mode == fsirq_pkg::FSIRQ_RUN, online};
        default:               next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode        <= fsirq_pkg::FSIRQ_PROG;
      mw          <= '0;
      tw          <= '0;
      fault_code  <= `FSIRQ_RST_FAULT_CODE;
      setpoint    <= `FSIRQ_RST_SETPOINT;
      tick_cnt    <= 16'h0000;
      ivl_cnt     <= 16'h0000;
      in_froutine <= 1'b0;
      online      <= 1'b0;
      prdata      <= 32'h0000_0000;
    end else begin
      mode        <= next_mode;
      mw          <= next_mw;
      tw          <= next_tw;
      fault_code  <= next_fault_code;
      setpoint    <= next_setpoint;
      tick_cnt    <= next_tick_cnt;
      ivl_cnt     <= next_ivl_cnt;
      in_froutine <= next_in_froutine;
      online      <= next_online;
      prdata      <= next_prdata;
    end
  end

  // Outputs off and indicator lit unless the routine is running
  assign outputs_enable  = run_or_test & ~(mw.halted & ~in_froutine);
  assign fault_indicator = mode == fsirq_pkg::FSIRQ_FAULT;
  assign fault_routine_active = in_froutine;
  assign timed_irq_run   = tw.executing;
  assign program_access  = ~mw.lock & password_ok;

  // Application code range is advice; no check is made

  a_fault_mode_halt: assert property (
    @(posedge sys_clk) disable iff (rst)
    me_s2 && mode != fsirq_pkg::FSIRQ_RUN |=> mw.halted
      && mode == fsirq_pkg::FSIRQ_FAULT && fault_code == 16'h0001)
    else $error("major error did not halt");
  a_run_refused: assert property (
    @(posedge sys_clk) disable iff (rst)
    mw.halted && $stable(mw.halted) && mode != fsirq_pkg::FSIRQ_RUN
      && !ev[`FSIRQ_EV_POWER_UP] |=> mode != fsirq_pkg::FSIRQ_RUN)
    else $error("run entered while halted");
  a_disable_clears: assert property (
    @(posedge sys_clk) disable iff (rst)
    ev[`FSIRQ_EV_DISABLE_INSTR] |=> !tw.enable)
    else $error("disable left enable set");
  a_skip_pending: assert property (
    @(posedge sys_clk) disable iff (rst)
    expiry && !tw.enable && next_mode == mode |=> tw.pending)
    else $error("expiry did not set pending");
  a_fault_indicator_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    fault_indicator |-> !outputs_enable)
    else $error("outputs on in fault");
  // Only a lone exit pulse, so no clear can race it
  a_exit_to_fault: assert property (
    @(posedge sys_clk) disable iff (rst)
    in_froutine && mw.halted && !me_s2
      && ev == (16'h0001 << `FSIRQ_EV_FAULT_EXIT)
      |=> fault_indicator && !outputs_enable)
    else $error("routine exit kept outputs on");
  a_prog_clear_mode: assert property (
    @(posedge sys_clk) disable iff (rst)
    mw.halted && !me_s2 && ev == (16'h0001 << `FSIRQ_EV_PROG_CLEAR)
      |=> mode == fsirq_pkg::FSIRQ_PROG && !mw.halted)
    else $error("programmer clear did not reach program mode");
endmodule
`default_nettype wire

/* File: bench/fsirq_host.sv */
// Host model: user program and programming device on the register bus
`timescale 1ns/1ps
`default_nettype none
`include "fsirq_consts.svh"
module fsirq_host (
  input  wire logic        sys_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic             password_ok,
  output logic             major_error_pin
);
  logic [31:0] dummy_r;
  logic        dummy_e;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hfff;
    pwdata = 32'hffffffff;
    password_ok = 1'b0;
    major_error_pin = 1'b0;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a live one
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic pins(input logic pw, input logic me);
    @(posedge sys_clk);
    password_ok <= pw;
    major_error_pin <= me;
  endtask
  task automatic raise_app(input logic [15:0] code);
    logic [15:0] c;
    // Codes kept in the application range
    c = (code < 16'hff00 || code > 16'hff0f) ? 16'hff00 : code;
    xfer(1'b1, `FSIRQ_OFS_FAULT_CODE, {16'h0000, c}, dummy_r, dummy_e);
    xfer(1'b1, `FSIRQ_OFS_MODE_WORD, 32'h2000, dummy_r, dummy_e);
  endtask
  task automatic recover;
    xfer(1'b1, `FSIRQ_OFS_MODE_WORD, 32'h0, dummy_r, dummy_e);
    xfer(1'b1, `FSIRQ_OFS_EVENT, 32'h1 << `FSIRQ_EV_FAULT_EXIT,
         dummy_r, dummy_e);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_fault_status_and_timed_irq_flags.sv */
// Self-checking bench of the fault status and timed interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "fsirq_consts.svh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
  fails++; $display("FAIL t=%0t got=%h exp=%h", $time, g, x); end end
module tb_fault_status_and_timed_irq_flags;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } fsirq_row_s;
  localparam fsirq_row_s ROWS [8] = '{
    '{1'b0, `FSIRQ_OFS_MODE_WORD, 32'h0, 32'h0, 1'b0},
    '{1'b0, `FSIRQ_OFS_TIRQ_WORD, 32'h0, 32'h0, 1'b0},
    '{1'b0, `FSIRQ_OFS_SETPOINT, 32'h0, 32'h0, 1'b0},
    '{1'b1, `FSIRQ_OFS_FAULT_CODE, 32'hff05, 32'h0, 1'b0},
    '{1'b0, `FSIRQ_OFS_FAULT_CODE, 32'h0, 32'hff05, 1'b0},
    '{1'b0, `FSIRQ_OFS_FAULT_CODE, 32'h0, 32'hff05, 1'b0},
    '{1'b0, 12'h020, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h030, 32'h5, 32'h0, 1'b1}
  };
  logic                   sys_clk;
  logic                   rst;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic            [11:0] paddr;
  logic            [31:0] pwdata;
  logic            [31:0] prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   password_ok;
  logic                   major_error_pin;
  logic                   outputs_enable;
  logic                   fault_indicator;
  logic                   fault_routine_active;
  logic                   timed_irq_run;
  logic                   program_access;
  fsirq_pkg::fsirq_mode_e mode;
  logic            [31:0] r;
  logic                   e;
  int                     fails;
  int                     samples_checked;
  int                     i;
  fsirq_status #(.TICK_DIV(4)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .password_ok(password_ok),
    .major_error_pin(major_error_pin), .outputs_enable(outputs_enable),
    .fault_indicator(fault_indicator),
    .fault_routine_active(fault_routine_active),
    .timed_irq_run(timed_irq_run), .program_access(program_access),
    .mode(mode));
  fsirq_host u_host (
    .sys_clk(sys_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .password_ok(password_ok),
    .major_error_pin(major_error_pin));
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, r, e);
    @(negedge sys_clk);
  endtask
  task automatic ev(input int b);
    wr(`FSIRQ_OFS_EVENT, 32'h1 << b);
    @(negedge sys_clk);
  endtask
  task automatic wait_mode(input fsirq_pkg::fsirq_mode_e m);
    @(negedge sys_clk);
    for (i = 0; i < 100 && mode !== m; i++) @(negedge sys_clk);
  endtask
  task automatic wait_routine;
    for (i = 0; i < 100 && fault_routine_active !== 1'b1; i++)
      @(negedge sys_clk);
  endtask
  task automatic end_sim;
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Far longer than the whole sequence needs
  initial begin
    #(20 * 20000);
    fails++;
    end_sim;
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK(outputs_enable, 1'b0)
    foreach (ROWS[k]) begin
      u_host.xfer(ROWS[k].w, ROWS[k].a, ROWS[k].d, r, e);
      if (!ROWS[k].w) `CHK(r, ROWS[k].q)
      `CHK(e, ROWS[k].e)
    end
    u_host.pins(1'b1, 1'b0);
    @(negedge sys_clk);
    `CHK(program_access, 1'b1)
    wr(`FSIRQ_OFS_CONTROL, 32'h2);
    wait_mode(fsirq_pkg::FSIRQ_RUN);
    rd(`FSIRQ_OFS_MODE_WORD);
    `CHK(r[15], 1'b1)
    ev(`FSIRQ_EV_SCAN_END);
    rd(`FSIRQ_OFS_MODE_WORD);
    `CHK(r[15], 1'b0)
    wr(`FSIRQ_OFS_SETPOINT, 32'h2);
    repeat (30) @(negedge sys_clk);
    rd(`FSIRQ_OFS_TIRQ_WORD);
    `CHK(r[2:0], 3'b001)
    ev(`FSIRQ_EV_START_INSTR);
    rd(`FSIRQ_OFS_TIRQ_WORD);
    `CHK(r[1:0], 2'b10)
    for (i = 0; i < 200 && timed_irq_run !== 1'b1; i++) @(negedge sys_clk);
    `CHK(timed_irq_run, 1'b1)
    rd(`FSIRQ_OFS_TIRQ_WORD);
    `CHK(r[2], 1'b1)
    // Stop the timer so no new expiry races the routine end
    wr(`FSIRQ_OFS_SETPOINT, 32'h0);
    ev(`FSIRQ_EV_ROUTINE_END);
    `CHK(timed_irq_run, 1'b0)
    ev(`FSIRQ_EV_DISABLE_INSTR);
    rd(`FSIRQ_OFS_TIRQ_WORD);
    `CHK(r[1], 1'b0)
    ev(`FSIRQ_EV_ENABLE_INSTR);
    rd(`FSIRQ_OFS_TIRQ_WORD);
    `CHK(r[1], 1'b1)
    u_host.raise_app(16'hff03);
    wait_routine;
    `CHK(fault_routine_active, 1'b1)
    `CHK(outputs_enable, 1'b1)
    rd(`FSIRQ_OFS_FAULT_CODE);
    `CHK(r[15:0], 16'hff03)
    u_host.recover;
    wait_mode(fsirq_pkg::FSIRQ_RUN);
    `CHK(fault_routine_active, 1'b0)
    `CHK(mode, fsirq_pkg::FSIRQ_RUN)
    u_host.raise_app(16'hff0f);
    wait_routine;
    ev(`FSIRQ_EV_FAULT_EXIT);
    wait_mode(fsirq_pkg::FSIRQ_FAULT);
    `CHK(fault_indicator, 1'b1)
    `CHK(outputs_enable, 1'b0)
    wr(`FSIRQ_OFS_CONTROL, 32'h2);
    wr(`FSIRQ_OFS_CONTROL, 32'h4);
    @(negedge sys_clk);
    `CHK(mode, fsirq_pkg::FSIRQ_FAULT)
    ev(`FSIRQ_EV_PROG_CLEAR);
    wait_mode(fsirq_pkg::FSIRQ_PROG);
    `CHK(mode, fsirq_pkg::FSIRQ_PROG)
    u_host.pins(1'b1, 1'b1);
    wait_mode(fsirq_pkg::FSIRQ_FAULT);
    `CHK(mode, fsirq_pkg::FSIRQ_FAULT)
    rd(`FSIRQ_OFS_MODE_WORD);
    `CHK(r[13], 1'b1)
    rd(`FSIRQ_OFS_FAULT_CODE);
    `CHK(r[15:0], `FSIRQ_SYSTEM_CODE)
    u_host.pins(1'b1, 1'b0);
    repeat (4) @(posedge sys_clk);
    ev(`FSIRQ_EV_PROG_CLEAR);
    wait_mode(fsirq_pkg::FSIRQ_PROG);
    `CHK(mode, fsirq_pkg::FSIRQ_PROG)
    // Offline edit clears enable, online edit is ignored
    wr(`FSIRQ_OFS_TIRQ_WORD, 32'h0);
    rd(`FSIRQ_OFS_TIRQ_WORD);
    `CHK(r[1], 1'b0)
    wr(`FSIRQ_OFS_CONTROL, 32'h1);
    wr(`FSIRQ_OFS_TIRQ_WORD, 32'h2);
    rd(`FSIRQ_OFS_TIRQ_WORD);
    `CHK(r[1], 1'b0)
    // Run-always power-up overrides a standing fault
    wr(`FSIRQ_OFS_MODE_WORD, 32'h1000);
    ev(`FSIRQ_EV_MAJOR_ERR);
    wait_mode(fsirq_pkg::FSIRQ_FAULT);
    ev(`FSIRQ_EV_POWER_UP);
    wait_mode(fsirq_pkg::FSIRQ_RUN);
    `CHK(mode, fsirq_pkg::FSIRQ_RUN)
    rd(`FSIRQ_OFS_MODE_WORD);
    `CHK(r[13], 1'b0)
    `CHK(r[15], 1'b1)
    // Startup protection keeps first scan through the routine
    wr(`FSIRQ_OFS_MODE_WORD, 32'h0200);
    ev(`FSIRQ_EV_POWER_UP);
    wait_routine;
    ev(`FSIRQ_EV_SCAN_END);
    rd(`FSIRQ_OFS_MODE_WORD);
    `CHK(r[15], 1'b1)
    `CHK(fault_routine_active, 1'b1)
    end_sim;
  end
endmodule
`default_nettype wire
